// ==== core/cpu_pkg.sv ====
// Constants shared by the compare and modulation unit.
// Assumes one core clock; offsets index an 8-bit register port.
package cpu_pkg;

    // ==========================================================
    // Register indices
    localparam logic [3:0] CPU_IDX_CONTROL   = 4'h0;
    localparam logic [3:0] CPU_IDX_DUTY_LOW  = 4'h1;
    localparam logic [3:0] CPU_IDX_ACT_DUTY  = 4'h2;
    localparam logic [3:0] CPU_IDX_PERIOD    = 4'h3;
    localparam logic [3:0] CPU_IDX_TMR_CTRL  = 4'h4;
    localparam logic [3:0] CPU_IDX_TIMER     = 4'h5;
    localparam logic [3:0] CPU_IDX_ALT_A     = 4'h6;
    localparam logic [3:0] CPU_IDX_ALT_B     = 4'h7;
    localparam logic [3:0] CPU_IDX_PIN_DIR   = 4'h8;
    localparam logic [3:0] CPU_IDX_STATUS    = 4'h9;
    localparam logic [3:0] CPU_IDX_MASK      = 4'hA;

    // ==========================================================
    // Field positions
    localparam int CPU_ENH_HI      = 7;
    localparam int CPU_ENH_LO      = 6;
    localparam int CPU_DLSB_HI     = 5;
    localparam int CPU_DLSB_LO     = 4;
    localparam int CPU_MODE_HI     = 3;
    localparam int CPU_TMR_ON_BIT  = 2;
    localparam int CPU_ST_MATCH    = 0;
    localparam int CPU_ST_PERIOD   = 1;

    // ==========================================================
    // Reset values and field masks
    localparam logic [7:0] CPU_RST_ZERO    = 8'h00;
    localparam logic [7:0] CPU_RST_PERIOD  = 8'hFF;
    localparam logic [7:0] CPU_RST_PIN_DIR = 8'h01;
    localparam logic [7:0] CPU_ENH_MASK    = 8'hC0;
    localparam logic [7:0] CPU_TMR_CTRL_M  = 8'h07;
    localparam logic [7:0] CPU_BIT0_M      = 8'h01;
    localparam logic [7:0] CPU_STATUS_M    = 8'h03;

    // ==========================================================
    // Prescale codes and the last prescaler count of each timer step
    localparam logic [1:0] CPU_PRE_1       = 2'h0;
    localparam logic [1:0] CPU_PRE_4       = 2'h1;
    localparam logic [5:0] CPU_LAST_PRE_1  = 6'h03;
    localparam logic [5:0] CPU_LAST_PRE_4  = 6'h0F;
    localparam logic [5:0] CPU_LAST_PRE_16 = 6'h3F;

    // ==========================================================
    // Mode codes
    typedef enum logic [3:0] {
        CPU_M_OFF    = 4'h0,
        CPU_M_TOGGLE = 4'h2,
        CPU_M_SET    = 4'h8,
        CPU_M_CLEAR  = 4'h9,
        CPU_M_SWINT  = 4'hA,
        CPU_M_SPEVT  = 4'hB
    } cpu_mode_e;

endpackage : cpu_pkg

// ==== core/cpu_unit.sv ====
// One compare / modulation unit; instantiate four times.
// Assumes the 16-bit compare timer value arrives from logic on core_clk,
// as do the sleep request; the pins are resolved by the port logic.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps

module cpu_unit
    import cpu_pkg::*;
#(
    parameter bit ENHANCED  = 1'b1,
    parameter bit ALT_IN_B  = 1'b0,
    parameter int ALT_BIT   = 0
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [15:0] cmp_timer,
    input  wire logic        sleep_req,
    output logic             pin_a_out,
    output logic             pin_a_oe,
    output logic             pin_b_out,
    output logic             pin_b_oe,
    output logic             pin_owned,
    output logic             cmp_timer_reset,
    output logic             conv_trigger,
    output logic             irq
);

    // ==========================================================
    // Registers
    logic [7:0]  unit_control_reg_q;
    logic [7:0]  duty_low_byte_q;
    logic [7:0]  active_duty_byte_q;
    logic [1:0]  active_duty_lsb_q;
    logic [7:0]  period_register_q;
    logic [7:0]  timer_control_reg_q;
    logic [7:0]  period_timer_q;
    logic [5:0]  presc_q;
    logic [7:0]  alt_pin_select_a_q;
    logic [7:0]  alt_pin_select_b_q;
    logic [7:0]  pin_dir_q;
    logic [1:0]  status_q;
    logic [1:0]  mask_q;
    logic        cmp_latch_q;
    logic        pwm_q;
    logic        match_seen_q;

    logic [3:0]  mode;
    logic        pwm_mode;
    logic        cmp_mode;
    logic        tmr_on;
    logic        pwm_level;
    logic [5:0]  presc_last;
    logic        tmr_step;
    logic        period_hit;
    logic [1:0]  tb_low;
    logic [9:0]  time_base;
    logic        cmp_eq;
    logic        cmp_event;
    logic        drive_pin;
    logic        alt_sel;
    logic [1:0]  status_set;

    function automatic logic wr_at(input logic [3:0] idx);
        wr_at = reg_wr && (reg_addr == idx);
    endfunction : wr_at

    assign mode     = unit_control_reg_q[CPU_MODE_HI:0];
    assign pwm_mode = (mode[3:2] == 2'h3);
    assign cmp_mode = (mode[3] || mode == CPU_M_TOGGLE) && !pwm_mode;
    assign tmr_on   = timer_control_reg_q[CPU_TMR_ON_BIT];

    // ==========================================================
    // Control and data registers
    // reset defaults
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            unit_control_reg_q  <= CPU_RST_ZERO;
            duty_low_byte_q     <= CPU_RST_ZERO;
            period_register_q   <= CPU_RST_PERIOD;
            timer_control_reg_q <= CPU_RST_ZERO;
            alt_pin_select_a_q  <= CPU_RST_ZERO;
            alt_pin_select_b_q  <= CPU_RST_ZERO;
            pin_dir_q           <= CPU_RST_PIN_DIR;
            mask_q              <= 2'h0;
        end else begin
            if (wr_at(CPU_IDX_CONTROL)) begin
                unit_control_reg_q <= ENHANCED ? reg_wdata
                                    : (reg_wdata & ~CPU_ENH_MASK);
            end
            if (wr_at(CPU_IDX_DUTY_LOW)) begin
                duty_low_byte_q <= reg_wdata;
            end
            if (wr_at(CPU_IDX_PERIOD)) begin
                period_register_q <= reg_wdata;
            end
            if (wr_at(CPU_IDX_TMR_CTRL)) begin
                timer_control_reg_q <= reg_wdata & CPU_TMR_CTRL_M;
            end
            if (wr_at(CPU_IDX_ALT_A)) begin
                alt_pin_select_a_q <= reg_wdata & CPU_BIT0_M;
            end
            if (wr_at(CPU_IDX_ALT_B)) begin
                alt_pin_select_b_q <= reg_wdata & CPU_BIT0_M;
            end
            if (wr_at(CPU_IDX_PIN_DIR)) begin
                pin_dir_q <= reg_wdata & CPU_BIT0_M;
            end
            if (wr_at(CPU_IDX_MASK)) begin
                mask_q <= reg_wdata[1:0];
            end
        end
    end

    // ==========================================================
    // Period timer and prescaler
    // prescale from timer control
    always_comb begin
        case (timer_control_reg_q[1:0])
            CPU_PRE_1: begin
                presc_last = CPU_LAST_PRE_1;
                tb_low     = presc_q[1:0];
            end
            CPU_PRE_4: begin
                presc_last = CPU_LAST_PRE_4;
                tb_low     = presc_q[3:2];
            end
            default: begin
                presc_last = CPU_LAST_PRE_16;
                tb_low     = presc_q[5:4];
            end
        endcase
    end

    // The timer freezes in sleep, so it resumes from where it stopped
    assign tmr_step   = tmr_on && !sleep_req && (presc_q == presc_last);
    assign period_hit = (period_timer_q == period_register_q);
    assign time_base  = {period_timer_q, tb_low};

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            presc_q <= 6'h00;
        end else if (!tmr_on || wr_at(CPU_IDX_TMR_CTRL)) begin
            presc_q <= 6'h00;
        end else if (!sleep_req) begin
            presc_q <= tmr_step ? 6'h00 : presc_q + 6'h01;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            period_timer_q <= CPU_RST_ZERO;
        end else if (wr_at(CPU_IDX_TIMER)) begin
            period_timer_q <= reg_wdata;
        end else if (tmr_step) begin
            period_timer_q <= period_hit ? CPU_RST_ZERO
                                         : period_timer_q + 8'h01;
        end
    end

    // ==========================================================
    // Duty double buffer and waveform
    // duty loads at period match
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            active_duty_byte_q <= CPU_RST_ZERO;
            active_duty_lsb_q  <= 2'h0;
        end else if (pwm_mode) begin
            if (tmr_step && period_hit) begin
                active_duty_byte_q <= duty_low_byte_q;
                active_duty_lsb_q  <=
                    unit_control_reg_q[CPU_DLSB_HI:CPU_DLSB_LO];
            end
        end else if (wr_at(CPU_IDX_ACT_DUTY)) begin
            // Read-only while modulating
            active_duty_byte_q <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_q <= 1'b0;
        end else if (!pwm_mode) begin
            pwm_q <= 1'b0;
        end else if (tmr_step && period_hit) begin
            pwm_q <= ({duty_low_byte_q,
                       unit_control_reg_q[CPU_DLSB_HI:CPU_DLSB_LO]}
                      != 10'h000);
        end else if (!sleep_req &&
                     time_base == {active_duty_byte_q,
                                   active_duty_lsb_q}) begin
            pwm_q <= 1'b0;
        end
    end

    // Low from the first clock of the match, so the width is duty times the prescale in clocks
    assign pwm_level = pwm_q && (time_base !=
                                 {active_duty_byte_q, active_duty_lsb_q});

    // ==========================================================
    // Compare path
    assign cmp_eq = (cmp_timer == {active_duty_byte_q, duty_low_byte_q});
    assign cmp_event = cmp_mode && cmp_eq && !match_seen_q && !sleep_req;

    // One event per match, not one per cycle the timer sits on it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            match_seen_q <= 1'b0;
        end else if (!sleep_req) begin
            match_seen_q <= cmp_mode && cmp_eq;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_latch_q <= 1'b0;
        end else if (mode == CPU_M_OFF) begin
            cmp_latch_q <= 1'b0;
        end else if (cmp_event) begin
            case (mode)
                CPU_M_TOGGLE: cmp_latch_q <= !cmp_latch_q;
                CPU_M_SET:    cmp_latch_q <= 1'b1;
                CPU_M_CLEAR:  cmp_latch_q <= 1'b0;
                default:      cmp_latch_q <= cmp_latch_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cmp_timer_reset <= 1'b0;
            conv_trigger    <= 1'b0;
        end else begin
            cmp_timer_reset <= cmp_event && (mode == CPU_M_SPEVT);
            conv_trigger    <= cmp_event && (mode == CPU_M_SPEVT);
        end
    end

    // ==========================================================
    // Pin control
    // zero control releases pin
    assign drive_pin = (mode != CPU_M_OFF) && (mode != CPU_M_SWINT)
                       && (mode != CPU_M_SPEVT);
    assign alt_sel = ALT_IN_B ? alt_pin_select_b_q[ALT_BIT]
                              : alt_pin_select_a_q[ALT_BIT];

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_a_out <= 1'b0;
            pin_a_oe  <= 1'b0;
            pin_b_out <= 1'b0;
            pin_b_oe  <= 1'b0;
            pin_owned <= 1'b0;
        end else begin
            pin_a_out <= !alt_sel && (pwm_mode ? pwm_level : cmp_latch_q);
            pin_b_out <= alt_sel && (pwm_mode ? pwm_level : cmp_latch_q);
            pin_a_oe  <= drive_pin && !alt_sel && !pin_dir_q[0];
            pin_b_oe  <= drive_pin && alt_sel && !pin_dir_q[0];
            pin_owned <= drive_pin;
        end
    end

    // ==========================================================
    // Status, mask and interrupt
    // flag on match
    assign status_set = {pwm_mode && tmr_step && period_hit, cmp_event};

    // A set arriving with the clearing read wins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            status_q <= 2'h0;
        end else begin
            status_q <= status_set
                      | ((reg_rd && reg_addr == CPU_IDX_STATUS)
                         ? 2'h0 : status_q);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // ==========================================================
    // Read port
    // unused bits read zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= CPU_RST_ZERO;
        end else if (!reg_rd) begin
            reg_rdata <= CPU_RST_ZERO;
        end else begin
            case (reg_addr)
                CPU_IDX_CONTROL:  reg_rdata <= unit_control_reg_q;
                CPU_IDX_DUTY_LOW: reg_rdata <= duty_low_byte_q;
                CPU_IDX_ACT_DUTY: reg_rdata <= active_duty_byte_q;
                CPU_IDX_PERIOD:   reg_rdata <= period_register_q;
                CPU_IDX_TMR_CTRL: reg_rdata <= timer_control_reg_q;
                CPU_IDX_TIMER:    reg_rdata <= period_timer_q;
                CPU_IDX_ALT_A:    reg_rdata <= alt_pin_select_a_q;
                CPU_IDX_ALT_B:    reg_rdata <= alt_pin_select_b_q;
                CPU_IDX_PIN_DIR:  reg_rdata <= pin_dir_q;
                CPU_IDX_STATUS:   reg_rdata <= {6'h00, status_q};
                CPU_IDX_MASK:     reg_rdata <= {6'h00, mask_q};
                default:          reg_rdata <= CPU_RST_ZERO;
            endcase
        end
    end

endmodule : cpu_unit

// ==== testbench/cpu_unit_properties.sv ====
// Concurrent checks on the ports of one compare / modulation unit.
// Assumes one core clock and the asynchronous active-low reset.
`timescale 1ns/1ps
module cpu_unit_checker
    import cpu_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       sleep_req,
    input wire logic       pin_a_oe,
    input wire logic       pin_b_oe,
    input wire logic       pin_owned,
    input wire logic       cmp_timer_reset,
    input wire logic       conv_trigger,
    input wire logic       irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Sequences
    sequence s_ctrl_zero;
        reg_wr && reg_addr == CPU_IDX_CONTROL && reg_wdata == 8'h00;
    endsequence
    sequence s_mask_zero;
        reg_wr && reg_addr == CPU_IDX_MASK && reg_wdata == 8'h00;
    endsequence
    // ==========================================================
    // Properties
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read answer");
    property p_unmapped;
        reg_rd && reg_addr > CPU_IDX_MASK |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped index read not zero");
    property p_pulse_one;
        cmp_timer_reset |=> !cmp_timer_reset;
    endproperty
    a_pulse_one: assert property (p_pulse_one)
        else $error("timer reset pulse longer than one cycle");
    property p_trig_pair;
        conv_trigger == cmp_timer_reset;
    endproperty
    a_trig_pair: assert property (p_trig_pair)
        else $error("conversion trigger differs from timer reset");
    property p_oe_owned;
        pin_a_oe || pin_b_oe |-> pin_owned;
    endproperty
    a_oe_owned: assert property (p_oe_owned)
        else $error("pin driven while unit does not claim it");
    property p_zero_owned;
        s_ctrl_zero |-> ##[1:2] !pin_owned;
    endproperty
    a_zero_owned: assert property (p_zero_owned)
        else $error("pin still claimed after zero control");
    property p_zero_oe;
        s_ctrl_zero |-> ##[1:3] (!pin_a_oe && !pin_b_oe);
    endproperty
    a_zero_oe: assert property (p_zero_oe)
        else $error("pin still driven after zero control");
    property p_sleep;
        sleep_req [*3] |-> !cmp_timer_reset;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("compare action while asleep");
    property p_sticky;
        irq && !reg_rd && !reg_wr && !$past(reg_rd) && !$past(reg_wr)
            |=> irq;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("interrupt dropped without a register access");
    property p_mask_off;
        s_mask_zero |-> ##2 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt high with mask cleared");
endmodule : cpu_unit_checker

bind cpu_unit cpu_unit_checker u_cpu_unit_checker (
    .core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_req, .pin_a_oe, .pin_b_oe, .pin_owned,
    .cmp_timer_reset, .conv_trigger, .irq
);

// ==== testbench/cpu_load_model.sv ====
// Load on the unit's output: resolves both pin locations.
// Assumes a pull-down on the load, so an undriven pin reads low.
`timescale 1ns/1ps
module cpu_load_model (
    input  wire logic pin_a_out,
    input  wire logic pin_a_oe,
    input  wire logic pin_b_out,
    input  wire logic pin_b_oe,
    output logic      pin_level
);
    // Pull-down wins whenever no location drives the pin
    assign pin_level = (pin_a_oe & pin_a_out) | (pin_b_oe & pin_b_out);
endmodule : cpu_load_model

// ==== testbench/compare_pwm_unit_bench.sv ====
// Self-checking bench for one enhanced compare / modulation unit.
// Assumes the checker binds itself and the load model pulls down.
`timescale 1ns/1ps
module compare_pwm_unit_bench
    import cpu_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [15:0] cmp_timer = 16'h0000;
    logic        sleep_req = 1'b0;
    logic [7:0]  reg_rdata;
    logic        pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, pin_owned;
    logic        cmp_timer_reset, conv_trigger, irq, pin_level, lat, ev, own;
    int          fails = 0;
    int          checks = 0;
    int          per, pre, mult, duty, h;
    logic [23:0] mtab [6] = '{24'h00FFFF, 24'h04FB03, 24'h08FE00,
                              24'h07FE00, 24'h0AFC00, 24'h0CFF00};
    logic [7:0]  rtab [12] = '{8'h00, 8'h00, 8'h00, CPU_RST_PERIOD, 8'h00,
                     8'h00, 8'h00, 8'h00, CPU_RST_PIN_DIR, 8'h00, 8'h00, 8'h00};
    logic [3:0]  modes [6] = '{CPU_M_TOGGLE, CPU_M_SET, CPU_M_CLEAR,
                               CPU_M_TOGGLE, CPU_M_SWINT, CPU_M_SPEVT};

    always #20 core_clk = ~core_clk;

    cpu_unit u_cpu_unit (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cmp_timer, .sleep_req, .pin_a_out, .pin_a_oe,
        .pin_b_out, .pin_b_oe, .pin_owned, .cmp_timer_reset, .conv_trigger,
        .irq);
    cpu_load_model u_cpu_load_model (.pin_a_out, .pin_a_oe, .pin_b_out,
        .pin_b_oe, .pin_level);

    // ==========================================================
    // Helpers
    function automatic int exp_high(int d, int p, int m);
        if (d >= 4 * (p + 1))
            return 4 * (p + 1) * m;
        return d * m;
    endfunction : exp_high
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task clks(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : clks
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rchk
    task do_reset;
        resetn <= 1'b0;
        clks(3);
        resetn <= 1'b1;
        clks(1);
    endtask : do_reset
    // Equality lasts one cycle; returns one cycle after the event
    task hit;
        @(posedge core_clk);
        cmp_timer <= 16'hC35A;
        @(posedge core_clk);
        cmp_timer <= 16'h0000;
        #1;
    endtask : hit
    task report_and_stop;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // Tests
    initial begin
        void'($urandom(74211));
        do_reset();
        chk(16'({pin_a_oe, pin_b_oe, pin_owned, irq}), 16'h0000);
        for (int a = 0; a < 12; a++)
            rchk(4'(a), rtab[a]);
        for (int i = 0; i < 6; i++) begin
            wr(mtab[i][19:16], mtab[i][15:8]);
            rchk(mtab[i][19:16], mtab[i][7:0]);
        end
        $display("registers done");
        wr(CPU_IDX_PIN_DIR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            per = $urandom_range(7, 1);
            pre = $urandom_range(2, 0);
            mult = pre == 2 ? 16 : pre == 1 ? 4 : 1;
            duty = i == 0 ? 0 : i == 1 ? 4 * (per + 1)
                 : $urandom_range(4 * (per + 1) - 1, 1);
            wr(CPU_IDX_TMR_CTRL, 8'h00);
            wr(CPU_IDX_TIMER, 8'h00);
            wr(CPU_IDX_CONTROL, {2'b00, 2'(duty), 4'hC});
            wr(CPU_IDX_DUTY_LOW, 8'(duty >> 2));
            wr(CPU_IDX_ACT_DUTY, 8'($urandom));
            wr(CPU_IDX_PERIOD, 8'(per));
            wr(CPU_IDX_TMR_CTRL, 8'h04 | 8'(pre));
            clks(12 * (per + 1) * mult);
            h = 0;
            repeat (4 * (per + 1) * mult) begin
                @(posedge core_clk);
                #1;
                h = h + int'(pin_level);
            end
            chk(16'(h), 16'(exp_high(duty, per, mult)));
            rchk(CPU_IDX_ACT_DUTY, 8'(duty >> 2));
        end
        $display("modulation done");
        wr(CPU_IDX_TMR_CTRL, 8'h00);
        wr(CPU_IDX_CONTROL, 8'h00);
        clks(3);
        chk(16'({pin_owned, pin_a_oe}), 16'h0000);
        rchk(CPU_IDX_STATUS, 8'h02);
        wr(CPU_IDX_ACT_DUTY, 8'hC3);
        wr(CPU_IDX_DUTY_LOW, 8'h5A);
        wr(CPU_IDX_MASK, 8'h01);
        lat = 1'b0;
        for (int k = 0; k < 6; k++) begin
            wr(CPU_IDX_CONTROL, {4'h0, modes[k]});
            clks(2);
            ev = (modes[k] == CPU_M_SPEVT);
            own = (modes[k] < CPU_M_SWINT);
            hit();
            chk(16'({cmp_timer_reset, conv_trigger}), 16'({ev, ev}));
            if (modes[k] == CPU_M_TOGGLE)
                lat = !lat;
            else if (modes[k] == CPU_M_SET)
                lat = 1'b1;
            else if (modes[k] == CPU_M_CLEAR)
                lat = 1'b0;
            @(posedge core_clk);
            #1;
            chk(16'({pin_owned, pin_a_oe}), 16'({own, own}));
            chk(16'(pin_a_out & pin_a_oe), 16'(lat & own));
            chk(16'(irq), 16'h0001);
            rchk(CPU_IDX_STATUS, 8'h01);
        end
        clks(2);
        chk(16'(irq), 16'h0000);
        wr(CPU_IDX_MASK, 8'h00);
        wr(CPU_IDX_CONTROL, 8'h08);
        hit();
        clks(3);
        chk(16'(irq), 16'h0000);
        rchk(CPU_IDX_STATUS, 8'h01);
        @(posedge core_clk);
        sleep_req <= 1'b1;
        hit();
        clks(2);
        sleep_req <= 1'b0;
        rchk(CPU_IDX_STATUS, 8'h00);
        $display("compare done");
        wr(CPU_IDX_ALT_A, 8'h01);
        clks(3);
        chk(16'({pin_a_oe, pin_b_oe, pin_level}), 16'h0003);
        do_reset();
        chk(16'({pin_a_oe, pin_b_oe, pin_owned}), 16'h0000);
        rchk(CPU_IDX_CONTROL, 8'h00);
        rchk(CPU_IDX_ALT_A, 8'h00);
        $display("reset done");
        report_and_stop();
    end

    // Longest path is under 20000 cycles
    initial begin
        #(40 * 40000);
        fails++;
        report_and_stop();
    end
endmodule : compare_pwm_unit_bench
